// >>> rtl/fmfc_pkg.sv
package fmfc_pkg;

   // ************************************************************
   // Clock and time base
   // ************************************************************
   localparam int CLK_PERIOD_NS = 4;
   localparam int MS_NS         = 1000000;
   localparam int MS_CYCLES     = MS_NS / CLK_PERIOD_NS;

   // Longest on-time, rounded down
   localparam int MAX_ON_NS     = 55000;
   localparam int MAX_ON_CYCLES = MAX_ON_NS / CLK_PERIOD_NS;

   // Lowest switching rate, longest period rounded down
   localparam int MIN_FREQ_KHZ      = 25;
   localparam int MAX_PERIOD_CYCLES = MS_NS / (MIN_FREQ_KHZ * CLK_PERIOD_NS);

   // Highest switching rate, least period rounded up
   localparam int MAX_FREQ_KHZ      = 125;
   localparam int MIN_PERIOD_CYCLES =
      (MS_NS + MAX_FREQ_KHZ * CLK_PERIOD_NS - 1) / (MAX_FREQ_KHZ * CLK_PERIOD_NS);

   // Grounding time of the mains sense pin per sample, rounded up
   localparam int SAMPLE_NS     = 8000;
   localparam int SAMPLE_CYCLES = (SAMPLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ************************************************************
   // Millisecond counts (one tick per ms) and overvoltage pulse count
   // ************************************************************
   localparam int BROWNOUT_MS       = 30;
   localparam int PAUSE_MS          = 6;
   localparam int PAUSE_BURST_MS    = 97;
   localparam int NO_SLOPE_MS       = 28;
   localparam int RESTART_MS        = 800;
   localparam int OP_RUN_MS         = 200;
   localparam int OP_START_MS       = 40;
   localparam int PROTECT_FILTER_MS = 3;
   localparam int OVP_PULSES        = 4;

   // ************************************************************
   // Counter widths
   // ************************************************************
   localparam int TICK_W = 18;
   localparam int ON_W   = 14;
   localparam int SMP_W  = 12;
   localparam int MS_W   = 10;

   // ************************************************************
   // Enumerations
   // ************************************************************
   typedef enum logic [3:0] {
      SW_IDLE   = 4'h1,
      SW_ON     = 4'h2,
      SW_DEMAG  = 4'h4,
      SW_VALLEY = 4'h8
   } fmfc_sw_type;

   typedef enum logic [3:0] {
      MODE_QR    = 4'h1,
      MODE_DCM   = 4'h2,
      MODE_FR    = 4'h4,
      MODE_BURST = 4'h8
   } fmfc_mode_type;

   typedef enum logic [1:0] {
      SECT_INPUT  = 2'h0,
      SECT_DEMAG  = 2'h1,
      SECT_OUTPUT = 2'h2,
      SECT_VALLEY = 2'h3
   } fmfc_sect_type;

   // ************************************************************
   // State of the controller
   // ************************************************************
   typedef struct packed {
      fmfc_sw_type   sw;
      fmfc_mode_type mode;
      fmfc_sect_type section;
      logic [TICK_W-1:0] tick_cnt;
      logic              tick;
      logic [ON_W-1:0]   on_cnt;
      logic [ON_W-1:0]   per_cnt;
      logic              skip;
      logic              dm_seen;
      logic              smp_busy;
      logic [SMP_W-1:0]  smp_cnt;
      logic              prev_bi;
      logic              prev_hi;
      logic              mains_ok;
      logic              disc;
      logic [6:0]        pause_cnt;
      logic [4:0]        bo_cnt;
      logic [4:0]        nodv_cnt;
      logic              cycle_op;
      logic              op_active;
      logic [7:0]        op_cnt;
      logic              startup;
      logic              ovp_seen;
      logic [2:0]        ovp_cnt;
      logic [1:0]        prot_cnt;
      logic              latched;
      logic              restart;
      logic [MS_W-1:0]   rst_cnt;
      logic              gate;
      logic              hv_pull;
      logic              supply;
      logic              pk_min;
   } fmfc_state_type;

   localparam fmfc_state_type STATE_RESET = '{
      sw: SW_IDLE, mode: MODE_QR, section: SECT_VALLEY, startup: 1'b1, default: '0};

endpackage

// >>> rtl/fmfc_sync.sv
`timescale 1ns/1ns
module fmfc_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             clk,
   input  wire logic             nrst,
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);

   // ************************************************************
   // Two-stage synchroniser
   // ************************************************************
   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] held;
   } fmfc_sync_type;

   fmfc_sync_type st;
   fmfc_sync_type next_st;

   // Shift new level in, first stage read only by second
   always_comb begin
      next_st.meta = d;
      next_st.held = st.meta;
   end

   // Register stages
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign q = st.held;

endmodule

// >>> rtl/fmfc_ctrl.sv
`timescale 1ns/1ns
// Function
// - Ground mains sense pin once per ms and read mains level.
// - Thirty consecutive 1 ms samples under brownout level stop switching.
// - Switching allowed only after mains rises above brownin level.
// - After mains detected, pause sampling 6 ms, 97 ms in burst.
// - Rising slope when successive samples cross brownin or mains-high level.
// - No slope for 28 ms: disconnected, pin held grounded continuously.
// - Any protection stops switching; type picks restart or latch.
// - Open auxiliary input stops at once, waits, no supply regulation.
// - Internal overtemperature latches at once; external after 2-3 ms filter.
// - Output overvoltage latches only after 4 consecutive confirming pulses.
// - Protect input in band: overvoltage counter clocked by 1 ms tick.
// - Above low reference runs overpower timer; 200 ms latches.
// - Above high reference ends the present gate pulse.
// - Start-up: 100 % cap, 40 ms; after feedback under 5 V, 150 %, 200 ms.
// - Lockout during overpower latches regardless of timer count.
// - Stopped by regulated protection: supply regulated via mains sense pin.
// - Valley mode starts cycle only after demagnetisation and valley.
// - Frequency reduction and burst keep rate at least 25 kHz, minimum peak.
// - Each cycle split into sections giving auxiliary input meaning.
module fmfc_ctrl #(
   parameter int unsigned MS_CYCLES         = fmfc_pkg::MS_CYCLES,
   parameter int unsigned MAX_ON_CYCLES     = fmfc_pkg::MAX_ON_CYCLES,
   parameter int unsigned MAX_PERIOD_CYCLES = fmfc_pkg::MAX_PERIOD_CYCLES
) (
   input  wire logic              clk,
   input  wire logic              nrst,
   input  wire logic              aux_open,
   input  wire logic              aux_demag,
   input  wire logic              aux_valley,
   input  wire logic              aux_ovp,
   input  wire logic              cs_peak,
   input  wire logic              cs_above_high_ref,
   input  wire logic              cs_above_low_ref,
   input  wire logic              hv_above_brownin,
   input  wire logic              hv_above_mains_high,
   input  wire logic              hv_below_brownout,
   input  wire logic              otp_internal,
   input  wire logic              protect_below_det,
   input  wire logic              protect_in_band,
   input  wire logic              ctrl_below_5v,
   input  wire logic              fb_fr_request,
   input  wire logic              fb_burst_request,
   input  wire logic              fb_burst_pause,
   input  wire logic              undervoltage_lockout,
   output logic                   driver_gate,
   output logic                   mains_sense_pull,
   output logic                   mains_supply_reg,
   output fmfc_pkg::fmfc_sect_type aux_section,
   output fmfc_pkg::fmfc_mode_type op_mode,
   output logic                   peak_min_hold,
   output logic                   startup_limit,
   output logic                   mains_ok,
   output logic                   mains_disconnected,
   output logic                   fault_latched,
   output logic                   restart_wait
);

   // ************************************************************
   // Reset release and input synchronisers
   // ************************************************************
   logic [1:0] rst_pipe;
   logic       rst_n;
   logic       s_open;
   logic       s_demag;
   logic       s_valley;
   logic       s_ovp;
   logic       s_peak;
   logic       s_high;
   logic       s_low;
   logic       s_bi;
   logic       s_hi;
   logic       s_bo;
   logic       s_otp;
   logic       s_prot;
   logic       s_band;
   logic       s_ctrl5;
   logic       s_fr;
   logic       s_burst;
   logic       s_pause;
   logic       s_undervoltage_lockout;

   // Reset released through two flip-flops
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rst_pipe <= 2'h0;
      end else begin
         rst_pipe <= {rst_pipe[0], 1'b1};
      end
   end
   assign rst_n = rst_pipe[1];

   fmfc_sync #(.WIDTH(18)) u_sync (
      .clk  (clk),
      .nrst (rst_n),
      .d    ({aux_open, aux_demag, aux_valley, aux_ovp, cs_peak, cs_above_high_ref,
              cs_above_low_ref, hv_above_brownin, hv_above_mains_high,
              hv_below_brownout, otp_internal, protect_below_det, protect_in_band,
              ctrl_below_5v, fb_fr_request, fb_burst_request, fb_burst_pause,
              undervoltage_lockout}),
      .q    ({s_open, s_demag, s_valley, s_ovp, s_peak, s_high, s_low, s_bi, s_hi,
              s_bo, s_otp, s_prot, s_band, s_ctrl5, s_fr, s_burst, s_pause, s_undervoltage_lockout})
   );

   // ************************************************************
   // Controller state
   // ************************************************************
   localparam int TW = fmfc_pkg::TICK_W;
   localparam int OW = fmfc_pkg::ON_W;
   localparam int SW = fmfc_pkg::SMP_W;
   localparam int MW = fmfc_pkg::MS_W;

   fmfc_pkg::fmfc_state_type st;
   fmfc_pkg::fmfc_state_type next_st;

   // Next state of the whole controller
   always_comb begin
      logic capture;
      logic slope;
      logic lost;
      logic max_on_hit;
      logic ext_otp;
      logic ovp_event;
      logic ovp_trip;
      logic op_trip;
      logic latch_set;
      logic run_ok;
      logic start_ok;
      logic burst_hold;
      capture    = 1'b0;
      slope      = 1'b0;
      lost       = 1'b0;
      max_on_hit = 1'b0;
      ext_otp    = 1'b0;
      ovp_event  = 1'b0;
      ovp_trip   = 1'b0;
      op_trip    = 1'b0;
      latch_set  = 1'b0;
      run_ok     = 1'b0;
      start_ok   = 1'b0;
      burst_hold = 1'b0;
      next_st    = st;

      // 1 ms tick divider
      next_st.tick = 1'b0;
      if (st.tick_cnt == TW'(MS_CYCLES - 1)) begin
         next_st.tick_cnt = '0;
         next_st.tick     = 1'b1;
      end else begin
         next_st.tick_cnt = st.tick_cnt + 1'b1;
      end

      // Mains sampling window, one per tick unless paused
      if (st.smp_busy) begin
         next_st.smp_cnt = st.smp_cnt + 1'b1;
         if (st.smp_cnt == SW'(fmfc_pkg::SAMPLE_CYCLES - 1)) begin
            capture          = 1'b1;
            next_st.smp_busy = 1'b0;
         end
      end else if (st.tick && st.pause_cnt == 7'h00) begin
         next_st.smp_busy = 1'b1;
         next_st.smp_cnt  = '0;
      end
      if (st.tick && st.pause_cnt != 7'h00) begin
         next_st.pause_cnt = st.pause_cnt - 1'b1;
      end

      // Mains level evaluation at end of sample
      slope = capture && ((!st.prev_bi && s_bi) || (!st.prev_hi && s_hi));
      if (capture) begin
         next_st.prev_bi = s_bi;
         next_st.prev_hi = s_hi;
         if (s_bi && (!st.disc || slope)) begin
            next_st.mains_ok = 1'b1;
         end
         if (!s_bo) begin
            next_st.bo_cnt = 5'h00;
         end else if (st.bo_cnt != 5'(fmfc_pkg::BROWNOUT_MS - 1)) begin
            next_st.bo_cnt = st.bo_cnt + 1'b1;
         end else begin
            lost             = st.mains_ok;
            next_st.mains_ok = 1'b0;
         end
      end

      // Slope pause and disconnect watchdog
      if (slope) begin
         next_st.nodv_cnt  = 5'h00;
         next_st.disc      = 1'b0;
         next_st.pause_cnt = (st.mode == fmfc_pkg::MODE_BURST) ?
                             7'(fmfc_pkg::PAUSE_BURST_MS) : 7'(fmfc_pkg::PAUSE_MS);
      end else if (st.tick && st.pause_cnt == 7'h00 && !st.disc) begin
         if (st.nodv_cnt == 5'(fmfc_pkg::NO_SLOPE_MS - 1)) begin
            next_st.disc     = 1'b1;
            next_st.mains_ok = 1'b0;
            lost             = 1'b1;
         end else begin
            next_st.nodv_cnt = st.nodv_cnt + 1'b1;
         end
      end
      next_st.hv_pull = next_st.smp_busy || next_st.disc;

      // External overtemperature filter on ticks
      if (!s_prot) begin
         next_st.prot_cnt = 2'h0;
      end else if (st.tick) begin
         if (st.prot_cnt == 2'(fmfc_pkg::PROTECT_FILTER_MS - 1)) begin
            ext_otp = 1'b1;
         end else begin
            next_st.prot_cnt = st.prot_cnt + 1'b1;
         end
      end

      // Overvoltage counter, driver pulses or ticks
      ovp_event = s_band ? st.tick :
                  (st.sw == fmfc_pkg::SW_DEMAG && st.dm_seen && !s_demag);
      if (ovp_event) begin
         next_st.ovp_seen = 1'b0;
         if (!st.ovp_seen) begin
            next_st.ovp_cnt = 3'h0;
         end else if (st.ovp_cnt == 3'(fmfc_pkg::OVP_PULSES - 1)) begin
            ovp_trip = 1'b1;
         end else begin
            next_st.ovp_cnt = st.ovp_cnt + 1'b1;
         end
      end
      if (st.sw == fmfc_pkg::SW_DEMAG && s_demag && s_ovp) begin
         next_st.ovp_seen = 1'b1;
      end

      // Overpower timer on ticks, limit by start-up state
      if (st.tick) begin
         if (!st.op_active) begin
            next_st.op_cnt = 8'h00;
         end else if (st.op_cnt == (st.startup ? 8'(fmfc_pkg::OP_START_MS - 1) :
                                    8'(fmfc_pkg::OP_RUN_MS - 1))) begin
            op_trip = 1'b1;
         end else begin
            next_st.op_cnt = st.op_cnt + 1'b1;
         end
      end

      // Protection manager: clear by mains loss, set wins
      max_on_hit = (st.sw == fmfc_pkg::SW_ON) && st.on_cnt == OW'(MAX_ON_CYCLES - 1);
      latch_set  = s_otp || ext_otp || ovp_trip || op_trip ||
                   (s_undervoltage_lockout && st.op_active);
      if (lost) begin
         next_st.latched = 1'b0;
         next_st.restart = 1'b0;
      end
      if (st.restart && st.tick) begin
         if (st.rst_cnt == MW'(fmfc_pkg::RESTART_MS - 1)) begin
            next_st.restart = 1'b0;
         end else begin
            next_st.rst_cnt = st.rst_cnt + 1'b1;
         end
      end
      if (latch_set) begin
         next_st.latched = 1'b1;
      end
      if (max_on_hit) begin
         next_st.restart = 1'b1;
         next_st.rst_cnt = '0;
      end
      run_ok = next_st.mains_ok && !next_st.latched && !next_st.restart &&
               !s_open && !s_undervoltage_lockout;
      next_st.supply = !run_ok && !s_open;
      if (!run_ok) begin
         next_st.startup = 1'b1;
      end else if (st.gate && s_ctrl5) begin
         next_st.startup = 1'b0;
      end

      // Switching cycle sequencer
      burst_hold = s_burst && s_pause;
      start_ok   = 1'b0;
      case (st.sw)
         fmfc_pkg::SW_IDLE: begin
            next_st.section = fmfc_pkg::SECT_VALLEY;
            start_ok        = !burst_hold;
         end
         fmfc_pkg::SW_ON: begin
            next_st.on_cnt = st.on_cnt + 1'b1;
            if (st.per_cnt != OW'(MAX_PERIOD_CYCLES - 1)) begin
               next_st.per_cnt = st.per_cnt + 1'b1;
            end
            if (s_low) begin
               next_st.cycle_op = 1'b1;
            end
            if (s_peak || s_high) begin
               next_st.gate    = 1'b0;
               next_st.sw      = fmfc_pkg::SW_DEMAG;
               next_st.dm_seen = 1'b0;
               next_st.section = fmfc_pkg::SECT_DEMAG;
            end
         end
         fmfc_pkg::SW_DEMAG: begin
            if (st.per_cnt != OW'(MAX_PERIOD_CYCLES - 1)) begin
               next_st.per_cnt = st.per_cnt + 1'b1;
            end
            if (s_demag) begin
               next_st.dm_seen = 1'b1;
               next_st.section = fmfc_pkg::SECT_OUTPUT;
            end else if (st.dm_seen) begin
               next_st.sw        = fmfc_pkg::SW_VALLEY;
               next_st.section   = fmfc_pkg::SECT_VALLEY;
               next_st.op_active = st.cycle_op;
            end
         end
         fmfc_pkg::SW_VALLEY: begin
            if (st.per_cnt != OW'(MAX_PERIOD_CYCLES - 1)) begin
               next_st.per_cnt = st.per_cnt + 1'b1;
            end
            if (s_valley && st.per_cnt < OW'(fmfc_pkg::MIN_PERIOD_CYCLES - 1)) begin
               next_st.skip = 1'b1;
            end
            if (burst_hold) begin
               next_st.sw = fmfc_pkg::SW_IDLE;
            end else if (s_valley && st.per_cnt >= OW'(fmfc_pkg::MIN_PERIOD_CYCLES - 1)) begin
               start_ok = 1'b1;
            end else if ((st.mode == fmfc_pkg::MODE_FR || st.mode == fmfc_pkg::MODE_BURST)
                         && st.per_cnt == OW'(MAX_PERIOD_CYCLES - 1)) begin
               start_ok = 1'b1;
            end
         end
         default: begin
            next_st.sw   = fmfc_pkg::SW_IDLE;
            next_st.gate = 1'b0;
         end
      endcase

      // New cycle: pick mode, raise gate
      if (start_ok && run_ok && !max_on_hit) begin
         next_st.sw       = fmfc_pkg::SW_ON;
         next_st.gate     = 1'b1;
         next_st.section  = fmfc_pkg::SECT_INPUT;
         next_st.on_cnt   = '0;
         next_st.per_cnt  = '0;
         next_st.cycle_op = 1'b0;
         next_st.skip     = 1'b0;
         if (s_burst) begin
            next_st.mode = fmfc_pkg::MODE_BURST;
         end else if (s_fr) begin
            next_st.mode = fmfc_pkg::MODE_FR;
         end else if (st.skip) begin
            next_st.mode = fmfc_pkg::MODE_DCM;
         end else begin
            next_st.mode = fmfc_pkg::MODE_QR;
         end
      end
      next_st.pk_min = (next_st.mode == fmfc_pkg::MODE_FR) ||
                       (next_st.mode == fmfc_pkg::MODE_BURST);

      // Any stop holds the driver low at once
      if (!run_ok || max_on_hit) begin
         next_st.sw        = fmfc_pkg::SW_IDLE;
         next_st.gate      = 1'b0;
         next_st.section   = fmfc_pkg::SECT_VALLEY;
         next_st.op_active = 1'b0;
      end
   end

   // Register the controller state
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st <= fmfc_pkg::STATE_RESET;
      end else begin
         st <= next_st;
      end
   end

   // ************************************************************
   // Outputs
   // ************************************************************
   assign driver_gate        = st.gate;
   assign mains_sense_pull   = st.hv_pull;
   assign mains_supply_reg   = st.supply;
   assign aux_section        = st.section;
   assign op_mode            = st.mode;
   assign peak_min_hold      = st.pk_min;
   assign startup_limit      = st.startup;
   assign mains_ok           = st.mains_ok;
   assign mains_disconnected = st.disc;
   assign fault_latched      = st.latched;
   assign restart_wait       = st.restart;

endmodule

// >>> dv/fmfc_ctrl_asserts.sv
`timescale 1ns/1ns
// ********
// Checker
// ********
module fmfc_ctrl_asserts #(
   parameter int unsigned MAX_ON_CYCLES = 40
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic otp_internal,
   input wire logic aux_open,
   input wire logic cs_above_high_ref,
   input wire logic driver_gate,
   input wire logic mains_sense_pull,
   input wire logic mains_supply_reg,
   input wire logic mains_disconnected,
   input wire logic fault_latched,
   input wire logic restart_wait
);
   logic [15:0] on_cnt;
   logic [15:0] pull_cnt;
   // Run lengths of gate and pull
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         on_cnt   <= '0;
         pull_cnt <= '0;
      end else begin
         on_cnt   <= driver_gate ? on_cnt + 16'h1 : '0;
         pull_cnt <= mains_sense_pull ? pull_cnt + 16'h1 : '0;
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   sample_len_a: assert property (
      $fell(mains_sense_pull) && !$past(mains_disconnected)
      |-> 32'(pull_cnt) == fmfc_pkg::SAMPLE_CYCLES) else $error("bad sample length");
   on_time_a: assert property (
      driver_gate |-> 32'(on_cnt) <= MAX_ON_CYCLES) else $error("on time too long");
   otp_latch_a: assert property (
      otp_internal |-> ##[1:4] fault_latched) else $error("no latch on overheat");
   latch_gate_a: assert property (
      fault_latched |=> !driver_gate) else $error("gate while latched");
   restart_gate_a: assert property (
      restart_wait |-> !driver_gate) else $error("gate while restarting");
   open_stop_a: assert property (
      aux_open [*5] |-> !driver_gate && !mains_supply_reg) else $error("open ignored");
   supply_reg_a: assert property (
      $rose(fault_latched) && !aux_open |-> ##[0:3] mains_supply_reg)
      else $error("supply not regulated");
   peak_end_a: assert property (
      driver_gate && cs_above_high_ref |-> ##[1:4] !driver_gate)
      else $error("pulse not cut");
endmodule
bind fmfc_ctrl fmfc_ctrl_asserts #(.MAX_ON_CYCLES(MAX_ON_CYCLES)) u_chk (
   .clk, .nrst, .otp_internal, .aux_open, .cs_above_high_ref, .driver_gate,
   .mains_sense_pull, .mains_supply_reg, .mains_disconnected, .fault_latched,
   .restart_wait);

// >>> dv/fmfc_stage.sv
`timescale 1ns/1ns
// ********
// Flyback stage model
// ********
module fmfc_stage (
   input  wire logic clk,
   input  wire logic driver_gate,
   input  wire logic stall_peak,
   output logic      cs_peak,
   output logic      aux_demag,
   output logic      aux_valley
);
   int unsigned on_t;
   int unsigned off_t;
   // Time since gate edge
   always_ff @(posedge clk) begin
      on_t  <= driver_gate ? on_t + 1 : 0;
      off_t <= driver_gate ? 0 : off_t + 1;
   end
   // Peak after 8 cycles, stroke of 40, ringing valleys every 50
   assign cs_peak    = driver_gate && !stall_peak && on_t >= 8;
   assign aux_demag  = !driver_gate && off_t >= 2 && off_t < 42;
   assign aux_valley = !driver_gate && off_t >= 42 && off_t % 50 >= 46;
endmodule

// >>> dv/testbench.sv
`timescale 1ns/1ns
// ********
// Testbench
// ********
module testbench;
   localparam int MSC = 2010;
   logic clk, nrst, stall_peak, aux_open, aux_demag, aux_valley, aux_ovp, cs_peak;
   logic cs_above_high_ref, cs_above_low_ref, hv_above_brownin, hv_above_mains_high;
   logic hv_below_brownout, otp_internal, protect_below_det, protect_in_band;
   logic ctrl_below_5v, fb_fr_request, fb_burst_request, fb_burst_pause;
   logic undervoltage_lockout, driver_gate, mains_sense_pull, mains_supply_reg;
   logic peak_min_hold, startup_limit, mains_ok, mains_disconnected;
   logic fault_latched, restart_wait;
   fmfc_pkg::fmfc_mode_type op_mode;
   fmfc_pkg::fmfc_sect_type aux_section;
   int failures;
   int tests_run;
   int n;
   fmfc_ctrl #(.MS_CYCLES(MSC), .MAX_ON_CYCLES(40), .MAX_PERIOD_CYCLES(2400)) dut (
      .clk, .nrst, .aux_open, .aux_demag, .aux_valley, .aux_ovp, .cs_peak,
      .cs_above_high_ref, .cs_above_low_ref, .hv_above_brownin, .hv_above_mains_high,
      .hv_below_brownout, .otp_internal, .protect_below_det, .protect_in_band,
      .ctrl_below_5v, .fb_fr_request, .fb_burst_request, .fb_burst_pause,
      .undervoltage_lockout, .driver_gate, .mains_sense_pull, .mains_supply_reg,
      .aux_section, .op_mode, .peak_min_hold, .startup_limit, .mains_ok,
      .mains_disconnected, .fault_latched, .restart_wait);
   fmfc_stage stage (.clk, .driver_gate, .stall_peak, .cs_peak, .aux_demag, .aux_valley);
   // Clock
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // Compare one bit
   task automatic chk(input logic got, input logic exp, input string msg);
      tests_run++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED %0t %s", $time, msg);
      end
   endtask
   // Bounded wait for a level
   task automatic wait_on(ref logic s, input logic v, input int lim);
      for (n = 0; n < lim && s !== v; n++) @(negedge clk);
   endtask
   // Reset with mains low, then mains present
   task automatic do_reset();
      nrst = 1'b0;
      hv_above_brownin = 1'b0;
      hv_above_mains_high = 1'b0;
      repeat (5) @(negedge clk);
      nrst = 1'b1;
      hv_above_brownin = 1'b1;
      hv_above_mains_high = 1'b1;
   endtask
   // Start-up, filter, limits, valley period, reduction, high reference
   task automatic t_startup();
      do_reset();
      repeat (MSC + 1000) @(negedge clk);
      chk(mains_sense_pull, 1'b1, "no sample");
      chk(driver_gate, 1'b0, "gate before mains");
      wait_on(driver_gate, 1'b1, 1200);
      chk(mains_ok, 1'b1, "no brownin");
      protect_below_det = 1'b1;
      repeat (MSC) @(negedge clk);
      protect_below_det = 1'b0;
      ctrl_below_5v = 1'b1;
      repeat (8) @(negedge clk);
      chk(fault_latched, 1'b0, "filter too short");
      wait_on(driver_gate, 1'b1, 3000);
      repeat (2) @(negedge clk);
      chk(startup_limit, 1'b0, "limit kept");
      wait_on(driver_gate, 1'b1, 3000);
      wait_on(driver_gate, 1'b0, 100);
      wait_on(driver_gate, 1'b1, 3000);
      chk(n > 1950 && driver_gate, 1'b1, "bad valley start");
      fb_fr_request = 1'b1;
      repeat (5000) @(negedge clk);
      chk(peak_min_hold, 1'b1, "no peak hold");
      chk(op_mode === fmfc_pkg::MODE_FR, 1'b1, "not reducing");
      fb_fr_request = 1'b0;
      wait_on(driver_gate, 1'b1, 3000);
      cs_above_high_ref = 1'b1;
      cs_above_low_ref = 1'b1;
      repeat (4) @(negedge clk);
      chk(driver_gate, 1'b0, "pulse not cut");
      cs_above_high_ref = 1'b0;
      cs_above_low_ref = 1'b0;
   endtask
   // Open auxiliary input stops and resumes
   task automatic t_open();
      wait_on(driver_gate, 1'b1, 3000);
      chk(aux_section === fmfc_pkg::SECT_INPUT, 1'b1, "bad section");
      aux_open = 1'b1;
      repeat (6) @(negedge clk);
      chk(driver_gate, 1'b0, "open ignored");
      chk(mains_supply_reg, 1'b0, "supply during open");
      aux_open = 1'b0;
      wait_on(driver_gate, 1'b1, 3000);
      chk(driver_gate, 1'b1, "no resume");
   endtask
   // On-time limit enters safe restart
   task automatic t_ontime();
      stall_peak = 1'b1;
      wait_on(restart_wait, 1'b1, 3000);
      chk(restart_wait, 1'b1, "no restart");
      repeat (4) @(negedge clk);
      chk(driver_gate, 1'b0, "gate after limit");
      chk(mains_supply_reg, 1'b1, "supply off");
      stall_peak = 1'b0;
   endtask
   // Internal overheating latches
   task automatic t_otp();
      do_reset();
      wait_on(driver_gate, 1'b1, 2 * MSC + 2100);
      otp_internal = 1'b1;
      repeat (6) @(negedge clk);
      otp_internal = 1'b0;
      chk(fault_latched, 1'b1, "no latch");
      chk(mains_supply_reg, 1'b1, "supply off");
      repeat (MSC) @(negedge clk);
      chk(fault_latched, 1'b1, "latch lost");
      chk(driver_gate, 1'b0, "gate while latched");
   endtask
   // Overvoltage count, then mains loss clears the latch
   task automatic t_ovp();
      do_reset();
      wait_on(driver_gate, 1'b1, 2 * MSC + 2100);
      aux_ovp = 1'b1;
      repeat (3000) @(negedge clk);
      chk(fault_latched, 1'b0, "latched early");
      wait_on(fault_latched, 1'b1, 6000);
      chk(fault_latched, 1'b1, "no overvoltage latch");
      aux_ovp = 1'b0;
      wait_on(mains_disconnected, 1'b1, 36 * MSC);
      chk(mains_disconnected, 1'b1, "no disconnect");
      chk(mains_sense_pull, 1'b1, "pin released");
      chk(fault_latched, 1'b0, "latch kept");
   endtask
   // Verdict
   task automatic wrap_up();
      $display("failures=%0d tests_run=%0d", failures, tests_run);
      if (failures == 0 && tests_run > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // Idle inputs, scenarios in order, then verdict
   initial begin
      failures = 0;
      tests_run = 0;
      {stall_peak, aux_open, aux_ovp, cs_above_high_ref, cs_above_low_ref, hv_below_brownout,
       otp_internal, protect_below_det, protect_in_band, ctrl_below_5v, fb_fr_request,
       fb_burst_request, fb_burst_pause, undervoltage_lockout} = '0;
      t_startup();
      t_open();
      t_ontime();
      t_otp();
      t_ovp();
      wrap_up();
   end
   // Watchdog just past the longest run
   initial begin
      repeat (100000) @(posedge clk);
      failures++;
      wrap_up();
   end
endmodule
